// File: core/chtb_pkg.sv
// Purpose: constants, register map and carriers for the card timeout/block config bank
// Assumes: AHB-Lite slave, 32-bit words, card clock sampled by hclk
// Notes: offsets are byte addresses of aligned words
// Contract
// - enable bit 4 gates response timeout irq, bit 3 gates read-data timeout irq.
// - enable bit 2 gates the command/response done interrupt.
// - enable bit 1 gates busy done, bit 0 gates data done interrupt.
// - response wait times out after 8-bit count of card clocks; zero disables.
// - response timeout flag with its enable set raises the interrupt.
// - data timeout is 26 bits, upper 10 in bits 17-8 of response register.
// - lower 16 data timeout bits sit in bits 15-0 of data timeout register.
// - read-data wait sets data timeout flag on expiry; zero count disables.
// - data timeout flag with its enable set raises the interrupt.
// - block length is a 12-bit byte count, values 1h to FFFh.
// - programmable block count sets blocks moved by a multi-block transfer.
// - count zero runs until stop command; nonzero n stops after n blocks.
// - interrupt follows only a 0-to-1 transition of a status flag; the code drives irq from the level of any set flag with its enable bit set.
package chtb_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_INT_MASK = 8'h00;
  localparam logic [7:0] OFS_RESP_TO = 8'h04;
  localparam logic [7:0] OFS_DATA_TO = 8'h08;
  localparam logic [7:0] OFS_BLK_LEN = 8'h0C;
  localparam logic [7:0] OFS_BLK_CNT = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_BLK_LEFT = 8'h18;
  // field layout
  localparam int EV_W = 5;
  localparam int BIT_DATA_DONE = 0;
  localparam int BIT_BUSY_DONE = 1;
  localparam int BIT_CMD_DONE = 2;
  localparam int BIT_DATA_TO = 3;
  localparam int BIT_RESP_TO = 4;
  localparam int RESP_CNT_W = 8;
  localparam int RESP_CNT_LSB = 0;
  localparam int DATA_HI_W = 10;
  localparam int DATA_HI_LSB = 8;
  localparam int DATA_LO_W = 16;
  localparam int DATA_CNT_W = DATA_HI_W + DATA_LO_W;
  localparam int BLK_LEN_W = 12;
  localparam int BLK_CNT_W = 16;
  // reset values
  localparam logic [EV_W-1:0] RST_EV = 5'h00;
  localparam logic [BLK_LEN_W-1:0] RST_BLK_LEN = 12'h000;
  localparam logic [BLK_CNT_W-1:0] RST_BLK_CNT = 16'h0000;
  localparam logic [31:0] RST_WORD = 32'h00000000;
  // ahb encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic HRESP_OKAY = 1'b0;

  // events from the rest of the controller, one-cycle pulses
  typedef struct packed {
    logic resp_wait_start;
    logic resp_received;
    logic data_wait_start;
    logic data_received;
    logic cmd_resp_done;
    logic busy_done;
    logic data_done;
    logic xfer_start;
    logic block_done;
    logic stop_cmd;
  } chtb_event_s;

  // configuration handed to the datapath
  typedef struct packed {
    logic [BLK_LEN_W-1:0] block_byte_length;
    logic [BLK_CNT_W-1:0] block_count_value;
    logic [BLK_CNT_W-1:0] blocks_left;
    logic xfer_active;
  } chtb_cfg_s;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_RD = 2'b10
  } chtb_bus_e;
endpackage

// File: core/chtb_config.sv
// Purpose: interrupt enables, response/read-data timeouts, block length and count
// Assumes: card clock is asynchronous to hclk and at most a quarter of its rate
// Notes: timeouts count rising card clock edges seen after a two-flop sync
`timescale 1ns/1ns
module chtb_config
  import chtb_pkg::*;
(
  // system
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // card side
  input wire logic card_clk,
  input wire chtb_event_s events,
  // results
  output chtb_cfg_s cfg,
  output logic xfer_done,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // register storage
  logic [EV_W-1:0] interrupt_enable_mask_reg;
  logic [EV_W-1:0] event_status_flags_reg;
  logic [EV_W-1:0] status_set;
  logic [RESP_CNT_W-1:0] resp_timeout_count_reg;
  logic [DATA_HI_W-1:0] data_timeout_count_high_reg;
  logic [DATA_LO_W-1:0] data_timeout_count_low_reg;
  logic [BLK_LEN_W-1:0] block_byte_length_reg;
  logic [BLK_CNT_W-1:0] block_count_value_reg;
  logic [BLK_CNT_W-1:0] blocks_left_reg;
  logic xfer_active_reg;
  logic xfer_done_reg;
  logic irq_reg;

  // bus pipeline
  chtb_bus_e bus_state_reg;
  logic wr_pend_reg;
  logic [7:0] addr_reg;
  logic [31:0] hrdata_reg;
  logic hreadyout_reg;
  logic addr_phase;

  // card clock sampling
  logic cclk_s1_reg;
  logic cclk_s2_reg;
  logic cclk_d_reg;
  logic card_tick;

  // timeout engines
  logic resp_wait_reg;
  logic [RESP_CNT_W-1:0] resp_cnt_reg;
  logic data_wait_reg;
  logic [DATA_CNT_W-1:0] data_cnt_reg;
  logic resp_expire;
  logic data_expire;
  logic [DATA_CNT_W-1:0] data_limit;

  // shared decode of a register offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // reserved bits forced to zero on every read
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    rd_mux = RST_WORD;
    if (hit(a, OFS_INT_MASK))
      rd_mux[EV_W-1:0] = interrupt_enable_mask_reg;
    else if (hit(a, OFS_RESP_TO))
    begin
      rd_mux[RESP_CNT_LSB +: RESP_CNT_W] = resp_timeout_count_reg;
      rd_mux[DATA_HI_LSB +: DATA_HI_W] = data_timeout_count_high_reg;
    end
    else if (hit(a, OFS_DATA_TO))
      rd_mux[DATA_LO_W-1:0] = data_timeout_count_low_reg;
    else if (hit(a, OFS_BLK_LEN))
      rd_mux[BLK_LEN_W-1:0] = block_byte_length_reg;
    else if (hit(a, OFS_BLK_CNT))
      rd_mux[BLK_CNT_W-1:0] = block_count_value_reg;
    else if (hit(a, OFS_STATUS))
      rd_mux[EV_W-1:0] = event_status_flags_reg;
    else if (hit(a, OFS_BLK_LEFT))
      rd_mux[BLK_CNT_W-1:0] = blocks_left_reg;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave
  assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

  // reads take one wait state so a write just before them is already stored
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_state_reg <= BUS_IDLE;
      wr_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
      hreadyout_reg <= 1'b1;
      hrdata_reg <= RST_WORD;
    end
    else
    begin
      case (bus_state_reg)
        BUS_IDLE:
        begin
          wr_pend_reg <= addr_phase && hwrite;
          if (addr_phase)
            addr_reg <= haddr;
          if (addr_phase && !hwrite)
          begin
            bus_state_reg <= BUS_RD;
            hreadyout_reg <= 1'b0;
          end
        end
        BUS_RD:
        begin
          hrdata_reg <= rd_mux(addr_reg);
          hreadyout_reg <= 1'b1;
          bus_state_reg <= BUS_IDLE;
        end
        default:
        begin
          bus_state_reg <= BUS_IDLE;
          hreadyout_reg <= 1'b1;
        end
      endcase
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = HRESP_OKAY; // constant, never an error

  // configuration writes land at the end of the write data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      interrupt_enable_mask_reg <= RST_EV;
      resp_timeout_count_reg <= '0;
      data_timeout_count_high_reg <= '0;
      data_timeout_count_low_reg <= '0;
      block_byte_length_reg <= RST_BLK_LEN;
      block_count_value_reg <= RST_BLK_CNT;
    end
    else if (wr_pend_reg)
    begin
      if (hit(addr_reg, OFS_INT_MASK))
        interrupt_enable_mask_reg <= hwdata[EV_W-1:0];
      if (hit(addr_reg, OFS_RESP_TO))
      begin
        resp_timeout_count_reg <= hwdata[RESP_CNT_LSB +: RESP_CNT_W];
        data_timeout_count_high_reg <= hwdata[DATA_HI_LSB +: DATA_HI_W];
      end
      if (hit(addr_reg, OFS_DATA_TO))
        data_timeout_count_low_reg <= hwdata[DATA_LO_W-1:0];
      if (hit(addr_reg, OFS_BLK_LEN))
        block_byte_length_reg <= hwdata[BLK_LEN_W-1:0];
      if (hit(addr_reg, OFS_BLK_CNT))
        block_count_value_reg <= hwdata[BLK_CNT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // card clock edge finder; first flop feeds only the second
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cclk_s1_reg <= 1'b0;
      cclk_s2_reg <= 1'b0;
      cclk_d_reg <= 1'b0;
    end
    else
    begin
      cclk_s1_reg <= card_clk;
      cclk_s2_reg <= cclk_s1_reg;
      cclk_d_reg <= cclk_s2_reg;
    end
  end

  assign card_tick = cclk_s2_reg && !cclk_d_reg;

  ////////////////////////////////////////////////////////////////////////////
  // response timeout: counts card clocks down from the limit
  assign resp_expire = resp_wait_reg && card_tick
    && (resp_cnt_reg == RESP_CNT_W'(1)) && !events.resp_received
    && !events.resp_wait_start; // a restart beats expiry

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      resp_wait_reg <= 1'b0;
      resp_cnt_reg <= '0;
    end
    else if (events.resp_wait_start)
    begin
      resp_cnt_reg <= resp_timeout_count_reg;
      resp_wait_reg <= (resp_timeout_count_reg != '0); // zero limit means no timeout
    end
    else if (events.resp_received || resp_expire)
      resp_wait_reg <= 1'b0;
    else if (resp_wait_reg && card_tick)
      resp_cnt_reg <= resp_cnt_reg - RESP_CNT_W'(1);
  end

  // read-data timeout: high and low fields joined into one count
  assign data_limit = {data_timeout_count_high_reg, data_timeout_count_low_reg};
  assign data_expire = data_wait_reg && card_tick
    && (data_cnt_reg == DATA_CNT_W'(1)) && !events.data_received
    && !events.data_wait_start; // a restart beats expiry

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      data_wait_reg <= 1'b0;
      data_cnt_reg <= '0;
    end
    else if (events.data_wait_start)
    begin
      data_cnt_reg <= data_limit;
      data_wait_reg <= (data_limit != '0);
    end
    else if (events.data_received || data_expire)
      data_wait_reg <= 1'b0;
    else if (data_wait_reg && card_tick)
      data_cnt_reg <= data_cnt_reg - DATA_CNT_W'(1);
  end

  ////////////////////////////////////////////////////////////////////////////
  // block counter: zero count runs until a stop command
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      blocks_left_reg <= RST_BLK_CNT;
      xfer_active_reg <= 1'b0;
      xfer_done_reg <= 1'b0;
    end
    else
    begin
      xfer_done_reg <= 1'b0;
      if (events.xfer_start)
      begin
        blocks_left_reg <= block_count_value_reg;
        xfer_active_reg <= 1'b1;
      end
      else if (xfer_active_reg && events.stop_cmd)
      begin
        xfer_active_reg <= 1'b0;
        xfer_done_reg <= 1'b1;
      end
      else if (xfer_active_reg && events.block_done && blocks_left_reg != RST_BLK_CNT)
      begin
        blocks_left_reg <= blocks_left_reg - BLK_CNT_W'(1);
        if (blocks_left_reg == BLK_CNT_W'(1))
        begin
          xfer_active_reg <= 1'b0; // exactly n blocks
          xfer_done_reg <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky status, write one to clear; a new event beats the clear
  always_comb
  begin
    status_set = RST_EV;
    status_set[BIT_RESP_TO] = resp_expire;
    status_set[BIT_DATA_TO] = data_expire;
    status_set[BIT_CMD_DONE] = events.cmd_resp_done;
    status_set[BIT_BUSY_DONE] = events.busy_done;
    status_set[BIT_DATA_DONE] = events.data_done;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      event_status_flags_reg <= RST_EV;
    else if (wr_pend_reg && hit(addr_reg, OFS_STATUS))
      event_status_flags_reg <= (event_status_flags_reg & ~hwdata[EV_W-1:0]) | status_set;
    else
      event_status_flags_reg <= event_status_flags_reg | status_set;
  end

  // level irq: rises a cycle after any set flag has its enable bit set, even when the enable is written after the flag
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_reg <= 1'b0;
    else
      irq_reg <= |(event_status_flags_reg & interrupt_enable_mask_reg);
  end

  assign irq = irq_reg;
  assign xfer_done = xfer_done_reg;
  assign cfg.block_byte_length = block_byte_length_reg;
  assign cfg.block_count_value = block_count_value_reg;
  assign cfg.blocks_left = blocks_left_reg;
  assign cfg.xfer_active = xfer_active_reg;

endmodule

// File: tb/chtb_config_checker.sv
// Purpose: bus timing and block count checks at the bank ports
// Assumes: one hclk domain, hresetn async active low
// Notes: timeouts are judged by the bench
`timescale 1ns/1ns
module chtb_config_checker
  import chtb_pkg::*;
(
  // system and bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // block transfer
  input wire chtb_event_s events,
  input wire chtb_cfg_s cfg,
  input wire logic xfer_done
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////////
  // taken transfer, and a block step with no start or stop beside it
  logic take;
  logic step;
  assign take = hsel && hready && htrans[1];
  assign step = cfg.xfer_active && events.block_done && !events.stop_cmd && !events.xfer_start;
  sequence s_one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence s_xfer_end;
    xfer_done && !cfg.xfer_active;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_resp_okay: assert property (hresp == HRESP_OKAY)
    else $error("hresp not okay");
  a_read_wait: assert property (take && !hwrite |=> s_one_wait)
    else $error("read wait state wrong");
  a_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  a_xfer_load: assert property (events.xfer_start && !events.stop_cmd |=>
    cfg.xfer_active && cfg.blocks_left == $past(cfg.block_count_value))
    else $error("count not loaded");
  a_block_dec: assert property (step && cfg.blocks_left > 16'h0001 |=>
    cfg.blocks_left == $past(cfg.blocks_left) - 16'h0001)
    else $error("count not decremented");
  a_last_block: assert property (step && cfg.blocks_left == 16'h0001 |=> s_xfer_end)
    else $error("last block did not end");
  a_stop_ends: assert property (events.stop_cmd && cfg.xfer_active |=> s_xfer_end)
    else $error("stop did not end");
  a_no_limit: assert property (step && cfg.blocks_left == 16'h0000 |=>
    cfg.xfer_active && !xfer_done)
    else $error("zero count ended");
endmodule
bind chtb_config chtb_config_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .events(events), .cfg(cfg), .xfer_done(xfer_done));

// File: tb/chtb_card_model.sv
// Purpose: card side clock for response and data waits
// Assumes: 80 ns card clock, run only inside a wait
// Notes: counts its rising edges since the last restart
`timescale 1ns/1ns
module chtb_card_model #(
  // byte length the card was set up with for reads
  parameter int card_read_block_len = 512
) (
  // from the bench
  input wire logic run,
  input wire logic restart,
  // card clock and edge count
  output logic card_clk,
  output int edges
);
  // parked low between waits so no stray edge reaches the counters
  initial card_clk = 1'b0;
  always #40 card_clk = run ? ~card_clk : 1'b0;
  // edges seen since the wait opened
  always @(posedge card_clk or posedge restart)
    if (restart)
      edges <= 0;
    else
      edges <= edges + 1;
endmodule

// File: tb/tb_card_host_timeout_and_block_config.sv
// Purpose: self-checking bench for the card timeout and block config bank
// Assumes: single AHB-Lite master, card clock only inside waits
// Notes: read data compared by a monitor against a queue
`timescale 1ns/1ns
module tb_card_host_timeout_and_block_config;
  import chtb_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, run = 1'b0;
  logic rst_cnt = 1'b0, rd_ph = 1'b0, hreadyout, hresp, card_clk, xfer_done, irq;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, r, exp_q[$];
  logic [31:0] msk[5] = '{32'h1F, 32'h3FFFF, 32'hFFFF, 32'hFFF, 32'hFFFF};
  chtb_event_s events = '0;
  chtb_cfg_s cfg;
  int edges, lim, n_done = 0, n_fail = 0, cmp_count = 0;
  always #5 hclk = ~hclk;
  chtb_config u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .card_clk(card_clk),
    .events(events), .cfg(cfg), .xfer_done(xfer_done), .irq(irq));
  chtb_card_model u_card (.run(run), .restart(rst_cnt), .card_clk(card_clk), .edges(edges));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask
  // address phase held until hready, then data phase until hready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  // events: 9 resp start, 7 data start, 5..3 done, 2 xfer start, 1 block, 0 stop
  task automatic pulse(input int b);
    events <= chtb_event_s'(10'h001 << b);
    @(posedge hclk);
    events <= '0;
    @(posedge hclk);
  endtask
  // open a wait, optionally restart it after two card edges, run until irq
  task automatic tmo(input int sb, input logic again);
    rst_cnt <= 1'b1;
    pulse(sb);
    rst_cnt <= 1'b0;
    run <= 1'b1;
    if (again)
    begin
      wait (edges == 2);
      repeat (4) @(posedge hclk);
      rst_cnt <= 1'b1;
      pulse(sb);
      rst_cnt <= 1'b0;
    end
    for (lim = 0; lim < 600 && irq !== 1'b1; lim++) // own bound on the wait
      @(posedge hclk);
    run <= 1'b0;
  endtask
  // read results pair with the oldest note; done pulses are counted
  always @(posedge hclk)
  begin
    if (rd_ph && hreadyout === 1'b1)
      chk("hrdata", exp_q.pop_front(), hrdata);
    if (hreadyout === 1'b1)
      rd_ph <= hsel && htrans[1] && !hwrite;
    if (xfer_done === 1'b1)
      n_done++;
  end
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    $display("FAIL watchdog exp end got hang");
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(81432));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (int a = 0; a < 32; a += 4)
      rd(8'(a), 32'h0);
    $display("reset test done");
    for (int i = 0; i < 5; i++)
    begin
      r = $urandom() | 32'h1; // nonzero keeps block length legal
      bus(1'b1, 8'(i * 4), r);
      rd(8'(i * 4), r & msk[i]);
    end
    bus(1'b1, OFS_BLK_LEFT, r);
    rd(OFS_BLK_LEFT, 32'h0);
    $display("field test done");
    bus(1'b1, OFS_INT_MASK, 32'h10);
    bus(1'b1, OFS_RESP_TO, 32'h3);
    tmo(9, 1'b1);
    chk("resp_edges", 32'h3, edges);
    rd(OFS_STATUS, 32'h10);
    bus(1'b1, OFS_STATUS, 32'h1F);
    repeat (2) @(posedge hclk);
    chk("irq_clear", 32'h0, irq);
    bus(1'b1, OFS_INT_MASK, 32'h08);
    bus(1'b1, OFS_DATA_TO, 32'h2);
    tmo(7, 1'b0);
    chk("data_edges", 32'h2, edges);
    rd(OFS_STATUS, 32'h08);
    bus(1'b1, OFS_STATUS, 32'h1F);
    bus(1'b1, OFS_RESP_TO, 32'h0);
    bus(1'b1, OFS_DATA_TO, 32'h0);
    tmo(9, 1'b0);
    tmo(7, 1'b0);
    rd(OFS_STATUS, 32'h0);
    $display("timeout test done");
    for (int m = 0; m < 2; m++)
      for (int b = 3; b < 6; b++)
      begin
        bus(1'b1, OFS_INT_MASK, (32'h1 << (b - 3)) ^ (m ? 32'h1F : 32'h0));
        pulse(b);
        @(posedge hclk);
        chk("irq_event", m ? 32'h0 : 32'h1, irq);
        rd(OFS_STATUS, 32'h1 << (b - 3));
        bus(1'b1, OFS_STATUS, 32'h1F);
      end
    $display("event test done");
    bus(1'b1, OFS_BLK_LEN, u_card.card_read_block_len);
    bus(1'b1, OFS_BLK_CNT, 32'h3);
    @(posedge hclk);
    chk("blk_len", u_card.card_read_block_len, cfg.block_byte_length);
    chk("blk_cnt", 32'h3, cfg.block_count_value);
    pulse(2);
    pulse(1);
    rd(OFS_BLK_LEFT, 32'h2);
    repeat (2) pulse(1);
    chk("xfer_n", 32'h0, cfg.xfer_active);
    bus(1'b1, OFS_BLK_CNT, 32'h0);
    pulse(2);
    repeat (3) pulse(1);
    chk("xfer_inf", 32'h1, cfg.xfer_active);
    pulse(0);
    repeat (2) @(posedge hclk);
    chk("done_count", 32'h2, n_done);
    $display("block test done");
    tally_and_finish();
  end
endmodule
